/* File: uiw_pkg.sv */
// Package with constants for the USB host interrupt and wake control block
package uiw_pkg;
    localparam int          UIW_NUM_EVT      = 8;
    localparam int          UIW_MAP_W        = 32;
    localparam int          UIW_NUM_CAT      = 3;
    localparam int          UIW_NUM_PORT     = 3;
    // Mode control bit positions
    localparam int          UIW_MODE_GIE     = 0;
    localparam int          UIW_MODE_TRIG    = 1;
    localparam int          UIW_MODE_POL     = 2;
    localparam int          UIW_MODE_OC_SEL  = 15;
    localparam logic [15:0] UIW_MODE_RST     = 16'h0000;
    // Edge count register fields
    localparam int          UIW_EDGE_W_LSB   = 0;
    localparam int          UIW_EDGE_W_MSB   = 15;
    localparam int          UIW_EDGE_G_LSB   = 24;
    localparam int          UIW_EDGE_G_MSB   = 31;
    localparam logic [31:0] UIW_EDGE_RST     = 32'h0000_0005;
    // Clock-off count field of power-down control
    localparam int          UIW_PD_CNT_LSB   = 16;
    localparam int          UIW_PD_CNT_MSB   = 31;
    localparam int          UIW_CORE_HZ      = 10_000_000;
    localparam int          UIW_SLOW_HZ      = 100_000;
    localparam int          UIW_SLOW_DIV     = UIW_CORE_HZ / UIW_SLOW_HZ;
    localparam int          UIW_CLKOFF_MS    = 10;
    localparam int          UIW_CLKOFF_MAXMS = 500;
    localparam logic [15:0] UIW_CLKOFF_RST   = 16'(UIW_CLKOFF_MS * UIW_SLOW_HZ / 1000);
    localparam int          UIW_READY_US     = 100;
    localparam int          UIW_READY_CYC    = UIW_READY_US * (UIW_CORE_HZ / 1_000_000);
    localparam logic [7:0]  UIW_READY_DLY    = 8'h0A;
    localparam int          UIW_EVT_READY    = 0;
    localparam int          UIW_EVT_WAKE     = 1;
    localparam int          UIW_EVT_ISO      = 2;
    localparam int          UIW_EVT_INT      = 3;
    localparam int          UIW_EVT_ASYNC    = 4;
    localparam logic [15:0] UIW_ONE16        = 16'h0001;
    localparam logic [7:0]  UIW_ONE8         = 8'h01;
    localparam logic [7:0]  UIW_DIV_LAST     = 8'(UIW_SLOW_DIV - 1);
    typedef enum logic [1:0] {UIW_AWAKE, UIW_SLEEP, UIW_RESUME} uiw_pwr_t;
endpackage : uiw_pkg

/* File: uiw_irq_wake.sv */
// Interrupt generation, descriptor masks, suspend and wake control
// Contract
// - Disabled event still sets its status bit but never drives the output.
// - Output needs global enable and an enabled pending status bit.
// - Level mode holds output until software clears all enabled pending bits.
// - Edge pulse runs its full width despite a clearing write.
// - Interrupt logic keeps running while main clocks are stopped.
// - Each descriptor category has its own AND and OR masks.
// - Done bit with its OR mask bit set raises an interrupt.
// - Remaining bits interrupt only when every AND-selected done bit is set.
// - Interval mode holds async completions until the timeout expires.
// - Done maps show which descriptors completed when interrupt fires.
// - Each OR-selected completion produces its own interrupt.
// - Suspend stops main clocks; slow clock near 100 kHz keeps running.
// - Resume on attach/detach, chip select, or low wake pin.
// - Wake pin released while suspended; low level starts wake-up.
// - Wake pin low means awake, high means suspended.
// - Resume clock-off counter; run bit before expiry makes resume permanent.
// - Clock-off count field covers delays up to about 655 ms.
// - Clocks-ready event raised after clocks restart following wake.
// - Mode bit 15 selects analog or digital overcurrent detection.
// - Overcurrent drops the port power switch output without software.
// - Writing one to a set status bit clears it.
// - Mode bits 0,1,2: global enable, trigger type, polarity; default level low.
// - Edge pulse width from edge count bits 15..0.
// - Edge count bits 31..24 set least gap between interrupts.
`timescale 1ns/1ps
module uiw_irq_wake
    import uiw_pkg::*;
(
    input  wire logic                                 core_clk,
    input  wire logic                                 rst,
    input  wire logic [15:0]                          mode_ctrl,
    input  wire logic [31:0]                          edge_count,
    input  wire logic [UIW_NUM_EVT-1:0]               irq_enable,
    input  wire logic [UIW_NUM_EVT-1:0]               status_clear,
    input  wire logic [UIW_NUM_EVT-1:0]               ext_event,
    input  wire logic [UIW_NUM_CAT*UIW_MAP_W-1:0]     done_set,
    input  wire logic [UIW_NUM_CAT*UIW_MAP_W-1:0]     done_clear,
    input  wire logic [UIW_NUM_CAT*UIW_MAP_W-1:0]     and_mask,
    input  wire logic [UIW_NUM_CAT*UIW_MAP_W-1:0]     or_mask,
    input  wire logic                                 async_interval_en,
    input  wire logic [15:0]                          async_timeout,
    input  wire logic [31:0]                          power_down_ctrl,
    input  wire logic                                 host_command_run,
    input  wire logic                                 suspend_req,
    input  wire logic                                 port_change,
    input  wire logic                                 chip_select_n,
    input  wire logic                                 sleep_wake_pin_n_in,
    input  wire logic                                 analog_overcurrent,
    input  wire logic [UIW_NUM_PORT-1:0]              port_overcurrent_n,
    input  wire logic [UIW_NUM_PORT-1:0]              port_power_on,
    output logic                                      irq_out,
    output logic [UIW_NUM_EVT-1:0]                    irq_status,
    output logic [UIW_NUM_CAT*UIW_MAP_W-1:0]          done_map,
    output logic                                      main_clk_en,
    output logic                                      slow_tick,
    output logic                                      sleep_wake_pin_n_out,
    output logic                                      sleep_wake_pin_n_oe,
    output logic [UIW_NUM_PORT-1:0]                   port_power_switch_n
);
    // Sync stages for pins
    logic                    wake_s1_ff, wake_s2_ff, cs_s1_ff, cs_s2_ff, pc_s1_ff, pc_s2_ff, aoc_s1_ff, aoc_s2_ff;
    logic [UIW_NUM_PORT-1:0] oc_s1_ff, oc_s2_ff;
    always_ff @(posedge core_clk)
    begin
        wake_s1_ff <= sleep_wake_pin_n_in;
        wake_s2_ff <= wake_s1_ff;
        cs_s1_ff   <= chip_select_n;
        cs_s2_ff   <= cs_s1_ff;
        pc_s1_ff   <= port_change;
        pc_s2_ff   <= pc_s1_ff;
        aoc_s1_ff  <= analog_overcurrent;
        aoc_s2_ff  <= aoc_s1_ff;
        oc_s1_ff   <= port_overcurrent_n;
        oc_s2_ff   <= oc_s1_ff;
    end

    // Slow suspend clock tick, never gated by suspend
    logic [7:0] div_ff;
    wire        tick = (div_ff == UIW_DIV_LAST);
    always_ff @(posedge core_clk)
    begin
        if (rst)
            div_ff <= 8'h00;
        else
            div_ff <= tick ? 8'h00 : div_ff + UIW_ONE8;
    end

    // Power state machine; sleep entry on a tick lets the released wake pin settle before it is sampled
    uiw_pwr_t    pwr_ff, nxt_pwr;
    logic [15:0] clkoff_ff, nxt_clkoff;
    logic [7:0]  rdy_ff;
    logic        wake_evt_ff, rdy_evt_ff;
    wire         wake_src  = ~wake_s2_ff | ~cs_s2_ff | pc_s2_ff;
    // clock-off count field, full 16 bits of slow ticks
    // up to about 655 ms at 10 us per tick
    wire [15:0]  clkoff_ld = power_down_ctrl[UIW_PD_CNT_MSB:UIW_PD_CNT_LSB];
    always_comb
    begin
        nxt_pwr    = pwr_ff;
        nxt_clkoff = clkoff_ff;
        case (pwr_ff)
            UIW_AWAKE:
                if (suspend_req && tick)
                    nxt_pwr = UIW_SLEEP;
            UIW_SLEEP:
                if (tick && wake_src)
                begin
                    nxt_pwr    = UIW_RESUME;
                    nxt_clkoff = clkoff_ld;
                end
            UIW_RESUME:
                if (host_command_run)
                    nxt_pwr = UIW_AWAKE;
                else if (tick)
                begin
                    if (clkoff_ff <= UIW_ONE16)
                        nxt_pwr = UIW_SLEEP;
                    nxt_clkoff = clkoff_ff - UIW_ONE16;
                end
            default:
                nxt_pwr = UIW_AWAKE;
        endcase
    end
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            pwr_ff      <= UIW_AWAKE;
            clkoff_ff   <= UIW_CLKOFF_RST;
            rdy_ff      <= 8'h00;
            wake_evt_ff <= 1'b0;
            rdy_evt_ff  <= 1'b0;
        end
        else
        begin
            pwr_ff      <= nxt_pwr;
            clkoff_ff   <= nxt_clkoff;
            wake_evt_ff <= (pwr_ff == UIW_SLEEP) && (nxt_pwr == UIW_RESUME);
            // clocks-ready event a short delay after restart
            rdy_ff      <= wake_evt_ff ? UIW_READY_DLY : (rdy_ff != 8'h00 ? rdy_ff - UIW_ONE8 : 8'h00);
            rdy_evt_ff  <= (rdy_ff == UIW_ONE8);
        end
    end

    // Descriptor done maps and mask evaluation
    logic [UIW_NUM_CAT*UIW_MAP_W-1:0] done_ff;
    logic [UIW_NUM_CAT*UIW_MAP_W-1:0] seen_ff;
    logic [UIW_NUM_CAT-1:0]           and_hit_ff;
    logic [UIW_NUM_CAT-1:0]           cat_evt;
    genvar c;
    generate
        for (c = 0; c < UIW_NUM_CAT; c++)
        begin : g_cat
            wire [UIW_MAP_W-1:0] dn  = done_ff[c*UIW_MAP_W +: UIW_MAP_W];
            wire [UIW_MAP_W-1:0] om  = or_mask[c*UIW_MAP_W +: UIW_MAP_W];
            wire [UIW_MAP_W-1:0] am  = and_mask[c*UIW_MAP_W +: UIW_MAP_W];
            wire [UIW_MAP_W-1:0] sn  = seen_ff[c*UIW_MAP_W +: UIW_MAP_W];
            wire                 or_hit  = |(dn & om & ~sn);
            // AND condition on bits outside the OR mask
            wire [UIW_MAP_W-1:0] am_eff  = am & ~om;
            wire                 and_now = (am_eff != '0) && ((dn & am_eff) == am_eff);
            assign cat_evt[c] = or_hit | (and_now & ~and_hit_ff[c]);
            always_ff @(posedge core_clk)
            begin
                if (rst)
                    and_hit_ff[c] <= 1'b0;
                else
                    and_hit_ff[c] <= and_now;
            end
        end
    endgenerate
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            done_ff <= '0;
            seen_ff <= '0;
        end
        else
        begin
            // done bits hold until cleared, set wins
            done_ff <= (done_ff & ~done_clear) | done_set;
            seen_ff <= (seen_ff | done_ff) & ~done_clear & ~done_set;
        end
    end

    // async interval holds completions until timeout
    logic [15:0] atmo_ff;
    logic        apend_ff;
    wire         atmo_exp = (atmo_ff == 16'h0000);
    wire         async_evt = async_interval_en ? (atmo_exp & (apend_ff | cat_evt[2])) : cat_evt[2];
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            atmo_ff  <= 16'h0000;
            apend_ff <= 1'b0;
        end
        else
        begin
            atmo_ff  <= (atmo_exp || !async_interval_en) ? async_timeout : atmo_ff - UIW_ONE16;
            apend_ff <= async_interval_en && !atmo_exp && (apend_ff | cat_evt[2]);
        end
    end

    // Event status register
    logic [UIW_NUM_EVT-1:0] evt_vec;
    always_comb
    begin
        evt_vec                = ext_event;
        evt_vec[UIW_EVT_READY] = ext_event[UIW_EVT_READY] | rdy_evt_ff;
        evt_vec[UIW_EVT_WAKE]  = ext_event[UIW_EVT_WAKE] | wake_evt_ff;
        evt_vec[UIW_EVT_ISO]   = ext_event[UIW_EVT_ISO] | cat_evt[0];
        evt_vec[UIW_EVT_INT]   = ext_event[UIW_EVT_INT] | cat_evt[1];
        evt_vec[UIW_EVT_ASYNC] = ext_event[UIW_EVT_ASYNC] | async_evt;
    end
    logic [UIW_NUM_EVT-1:0] stat_ff;
    always_ff @(posedge core_clk)
    begin
        if (rst)
            stat_ff <= '0;
        else
            // status set regardless of enable, write-one clears, set wins
            stat_ff <= (stat_ff & ~status_clear) | evt_vec;
    end

    wire        gie      = mode_ctrl[UIW_MODE_GIE];
    wire        edge_md  = mode_ctrl[UIW_MODE_TRIG];
    wire        pol_high = mode_ctrl[UIW_MODE_POL];
    wire        pend     = gie && |(stat_ff & irq_enable);
    wire        new_pend = gie && |(evt_vec & irq_enable);
    wire [15:0] pw       = edge_count[UIW_EDGE_W_MSB:UIW_EDGE_W_LSB];
    wire [7:0]  gap      = edge_count[UIW_EDGE_G_MSB:UIW_EDGE_G_LSB];

    logic [15:0] pulse_ff;
    logic [7:0]  gap_ff;
    logic        hold_ff;
    wire         pulse_on = (pulse_ff != 16'h0000);
    wire         start    = edge_md && (new_pend || hold_ff) && !pulse_on && (gap_ff == 8'h00);
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            pulse_ff <= 16'h0000;
            gap_ff   <= 8'h00;
            hold_ff  <= 1'b0;
        end
        else
        begin
            pulse_ff <= start ? ((pw == 16'h0000) ? UIW_ONE16 : pw) : (pulse_on ? pulse_ff - UIW_ONE16 : 16'h0000);
            gap_ff   <= (pulse_ff == UIW_ONE16) ? gap : ((gap_ff != 8'h00 && !pulse_on) ? gap_ff - UIW_ONE8 : gap_ff);
            hold_ff  <= edge_md && !start && (hold_ff || (new_pend && (pulse_on || gap_ff != 8'h00)));
        end
    end

    // level follows pending status; tick logic never gated
    wire irq_act = edge_md ? (start || (pulse_on && pulse_ff != UIW_ONE16)) : pend;

    wire [UIW_NUM_PORT-1:0] oc_hit = mode_ctrl[UIW_MODE_OC_SEL] ? ~oc_s2_ff : {UIW_NUM_PORT{aoc_s2_ff}};
    logic [UIW_NUM_PORT-1:0] oc_latch_ff;
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            irq_out              <= 1'b0;
            irq_status           <= '0;
            done_map             <= '0;
            main_clk_en          <= 1'b1;
            slow_tick            <= 1'b0;
            sleep_wake_pin_n_out <= 1'b0;
            sleep_wake_pin_n_oe  <= 1'b1;
            port_power_switch_n  <= '1;
            oc_latch_ff          <= '0;
        end
        else
        begin
            irq_out              <= irq_act ^ ~pol_high;
            irq_status           <= stat_ff;
            done_map             <= done_ff;
            // main clocks off only while asleep
            main_clk_en          <= (nxt_pwr != UIW_SLEEP);
            slow_tick            <= tick;
            // drive low when awake, release when asleep
            sleep_wake_pin_n_out <= 1'b0;
            sleep_wake_pin_n_oe  <= (nxt_pwr != UIW_SLEEP);
            oc_latch_ff          <= (oc_latch_ff & port_power_on) | oc_hit;
            port_power_switch_n  <= ~(port_power_on & ~oc_latch_ff & ~oc_hit);
        end
    end

    // Assertions
    // event with enable clear leaves output idle
    a_disabled_no_irq: assert property (@(posedge core_clk) disable iff (rst)
        (!edge_md && irq_enable == '0) |=> (irq_out == ~$past(pol_high)))
        else $error("irq active with all enables clear");
    a_status_set: assert property (@(posedge core_clk) disable iff (rst)
        evt_vec[UIW_EVT_ISO] |=> stat_ff[UIW_EVT_ISO])
        else $error("status not set after event");
    a_gie_gate: assert property (@(posedge core_clk) disable iff (rst)
        (!gie && !pulse_on && !start) |=> (irq_out == ~$past(pol_high)))
        else $error("irq active without global enable");
    a_level_hold: assert property (@(posedge core_clk) disable iff (rst)
        (!edge_md && pend) |=> (irq_out == $past(pol_high)))
        else $error("level irq dropped while pending");
    sequence s_pulse_run;
        pulse_on && pulse_ff != UIW_ONE16;
    endsequence
    a_edge_full: assert property (@(posedge core_clk) disable iff (rst)
        s_pulse_run |=> (pulse_ff == $past(pulse_ff) - UIW_ONE16))
        else $error("edge pulse shortened");
    a_or_fire: assert property (@(posedge core_clk) disable iff (rst)
        (|(done_ff[UIW_MAP_W-1:0] & or_mask[UIW_MAP_W-1:0] & ~seen_ff[UIW_MAP_W-1:0])) |=> stat_ff[UIW_EVT_ISO])
        else $error("OR mask completion missed");
    a_done_sticky: assert property (@(posedge core_clk) disable iff (rst)
        (done_ff[0] && !done_clear[0]) |=> done_ff[0])
        else $error("done bit lost");
    a_async_hold: assert property (@(posedge core_clk) disable iff (rst)
        (async_interval_en && !atmo_exp && !ext_event[UIW_EVT_ASYNC] && !stat_ff[UIW_EVT_ASYNC])
        |=> !stat_ff[UIW_EVT_ASYNC])
        else $error("async event before timeout");
    a_oc_cut: assert property (@(posedge core_clk) disable iff (rst)
        (mode_ctrl[UIW_MODE_OC_SEL] && !oc_s2_ff[0]) |=> port_power_switch_n[0])
        else $error("power not cut on overcurrent");
    a_sleep_release: assert property (@(posedge core_clk) disable iff (rst)
        (pwr_ff == UIW_SLEEP && nxt_pwr == UIW_SLEEP) |=> !sleep_wake_pin_n_oe)
        else $error("wake pin driven in suspend");
endmodule : uiw_irq_wake

/* File: uiw_host_model.sv */
// Processor-side model of the wake pin: pull-up plus a GPIO that can pull low
`timescale 1ns/1ps
module uiw_host_model
(
    input  wire logic dev_out,
    input  wire logic dev_oe,
    input  wire logic gpio_low,
    output logic      pin_level
);
    assign pin_level = dev_oe ? dev_out : (gpio_low ? 1'b0 : 1'b1);
endmodule : uiw_host_model

/* File: usb_host_irq_and_wake_control_test.sv */
// Self-checking bench for the interrupt and wake control block
`timescale 1ns/1ps
module usb_host_irq_and_wake_control_test;
    import uiw_pkg::*;
    typedef struct packed {logic [15:0] mode; logic [7:0] en; logic [7:0] evt; logic [7:0] st; logic irq;} uiw_row_t;
    logic              core_clk = 1'b0;
    logic              rst = 1'b1;
    logic [15:0]       mode_ctrl = 16'h0004;
    logic [31:0]       edge_count = 32'h0000_0005;
    logic [7:0]        irq_enable = 8'h00, status_clear = 8'h00, ext_event = 8'h00, irq_status;
    logic [95:0]       done_set = '0, done_clear = '0, and_mask = '0, or_mask = '0, done_map;
    logic              async_interval_en = 1'b0;
    logic [15:0]       async_timeout = 16'h00C8;
    logic [31:0]       power_down_ctrl = 32'h0003_0000;
    logic              host_command_run = 1'b0, suspend_req = 1'b0, port_change = 1'b0, chip_select_n = 1'b1;
    logic              analog_overcurrent = 1'b0, gpio_low = 1'b0;
    logic [2:0]        port_overcurrent_n = 3'h7, port_power_on = 3'h0, port_power_switch_n;
    logic              irq_out, main_clk_en, slow_tick, pin_out, pin_oe, pin_level;
    int                mismatches = 0, comparisons = 0, cycles = 0, i, n;
    uiw_row_t          rows [5] = '{'{16'h0005, 8'h04, 8'h04, 8'h04, 1'b1}, '{16'h0005, 8'h00, 8'h08, 8'h08, 1'b0},
                                    '{16'h0004, 8'h04, 8'h04, 8'h04, 1'b0}, '{16'h0001, 8'h20, 8'h20, 8'h20, 1'b0},
                                    '{16'h0005, 8'h80, 8'h40, 8'h40, 1'b0}};
    always #50 core_clk = ~core_clk;
    uiw_irq_wake dut (.core_clk(core_clk), .rst(rst), .mode_ctrl(mode_ctrl), .edge_count(edge_count),
        .irq_enable(irq_enable), .status_clear(status_clear), .ext_event(ext_event), .done_set(done_set),
        .done_clear(done_clear), .and_mask(and_mask), .or_mask(or_mask), .async_interval_en(async_interval_en),
        .async_timeout(async_timeout), .power_down_ctrl(power_down_ctrl), .host_command_run(host_command_run),
        .suspend_req(suspend_req), .port_change(port_change), .chip_select_n(chip_select_n),
        .sleep_wake_pin_n_in(pin_level), .analog_overcurrent(analog_overcurrent),
        .port_overcurrent_n(port_overcurrent_n), .port_power_on(port_power_on), .irq_out(irq_out),
        .irq_status(irq_status), .done_map(done_map), .main_clk_en(main_clk_en), .slow_tick(slow_tick),
        .sleep_wake_pin_n_out(pin_out), .sleep_wake_pin_n_oe(pin_oe), .port_power_switch_n(port_power_switch_n));
    uiw_host_model host (.dev_out(pin_out), .dev_oe(pin_oe), .gpio_low(gpio_low), .pin_level(pin_level));
    task summarize;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize
    task check(input string name, input logic [95:0] exp, input logic [95:0] seen);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // Outputs are read at the edge, before that edge's updates land
    task tick(input int k);
        repeat (k) @(posedge core_clk);
    endtask : tick
    task clear_status(input logic [7:0] v);
        status_clear <= v;
        tick(1);
        status_clear <= 8'h00;
        tick(3);
    endtask : clear_status
    task done_pulse(input logic [95:0] v);
        done_set <= v;
        tick(1);
        done_set <= '0;
        tick(3);
    endtask : done_pulse
    task wait_clk(input logic v, input int lim);
        for (int k = 0; k < lim && main_clk_en !== v; k++)
            tick(1);
    endtask : wait_clk
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            summarize();
        end
    end
    initial
    begin
        tick(5);
        rst <= 1'b0;
        tick(2);
        check("irq_out", 1'b0, irq_out);
        check("clk_en", 1'b1, main_clk_en);
        check("pin_oe", 1'b1, pin_oe);
        check("switch", 3'h7, port_power_switch_n);
        check("status", 8'h00, irq_status);
        n = 0;
        repeat (200)
        begin
            tick(1);
            if (slow_tick === 1'b1)
                n++;
        end
        check("slow_ticks", 2, n);
        $display("test reset done");
        for (i = 0; i < 5; i++)
        begin
            mode_ctrl <= rows[i].mode;
            irq_enable <= rows[i].en;
            ext_event <= rows[i].evt;
            tick(1);
            ext_event <= 8'h00;
            tick(3);
            check("row_status", rows[i].st, irq_status);
            check("row_irq", rows[i].irq, irq_out);
            clear_status(8'hFF);
            check("row_idle", !rows[i].mode[2], irq_out);
        end
        $display("test rows done");
        mode_ctrl <= 16'h0005;
        irq_enable <= 8'h1C;
        ext_event <= 8'h0C;
        tick(1);
        ext_event <= 8'h00;
        tick(3);
        clear_status(8'h04);
        check("level_hold", 1'b1, irq_out);
        clear_status(8'h08);
        check("level_drop", 1'b0, irq_out);
        $display("test level done");
        edge_count <= 32'h0000_0008;
        mode_ctrl <= 16'h0007;
        ext_event <= 8'h04;
        tick(1);
        ext_event <= 8'h00;
        for (n = 0; n < 10 && irq_out !== 1'b1; n++)
            tick(1);
        status_clear <= 8'h04;
        n = 0;
        while (n < 30 && irq_out === 1'b1)
        begin
            n++;
            tick(1);
            status_clear <= 8'h00;
        end
        check("pulse_width", 8, n);
        mode_ctrl <= 16'h0005;
        clear_status(8'hFF);
        // event during the pulse is held and pulses after the gap
        edge_count <= 32'h1400_0002;
        mode_ctrl <= 16'h0007;
        ext_event <= 8'h04;
        tick(1);
        ext_event <= 8'h08;
        tick(1);
        ext_event <= 8'h00;
        for (n = 0; n < 10 && irq_out !== 1'b0; n++)
            tick(1);
        for (n = 0; n < 60 && irq_out !== 1'b1; n++)
            tick(1);
        check("gap_held", 1'b1, n >= 20 && n < 40);
        mode_ctrl <= 16'h0005;
        clear_status(8'hFF);
        $display("test edge done");
        and_mask <= {32'h0, 32'h20, 32'h16};
        or_mask <= {32'h1, 32'h1, 32'h180};
        done_pulse({32'h0, 32'h10, 32'h6});
        check("and_partial", 8'h00, irq_status);
        check("map_partial", {32'h0, 32'h10, 32'h6}, done_map);
        done_pulse({64'h0, 32'h10});
        check("and_full", 8'h04, irq_status);
        clear_status(8'hFF);
        check("map_kept", {32'h0, 32'h10, 32'h16}, done_map);
        done_pulse({64'h0, 32'h80});
        check("or_first", 8'h04, irq_status);
        clear_status(8'hFF);
        done_pulse({64'h0, 32'h100});
        check("or_second", 8'h04, irq_status);
        check("map_or", {32'h0, 32'h10, 32'h196}, done_map);
        clear_status(8'hFF);
        done_pulse({32'h0, 32'h1, 32'h0});
        check("or_int", 8'h08, irq_status);
        clear_status(8'hFF);
        done_clear <= '1;
        tick(1);
        done_clear <= '0;
        tick(3);
        check("map_clear", 96'h0, done_map);
        $display("test masks done");
        async_interval_en <= 1'b1;
        done_pulse({32'h1, 64'h0});
        check("interval_hold", 1'b0, irq_status[UIW_EVT_ASYNC]);
        for (n = 0; n < 210 && irq_status[UIW_EVT_ASYNC] !== 1'b1; n++)
            tick(1);
        check("interval_fire", 1'b1, irq_status[UIW_EVT_ASYNC]);
        async_interval_en <= 1'b0;
        clear_status(8'hFF);
        $display("test interval done");
        mode_ctrl <= 16'h8005;
        port_power_on <= 3'h7;
        tick(4);
        check("power_on", 3'h0, port_power_switch_n);
        port_overcurrent_n <= 3'h5;
        tick(6);
        check("oc_cut", 3'h2, port_power_switch_n);
        port_overcurrent_n <= 3'h7;
        port_power_on <= 3'h0;
        tick(4);
        check("power_off", 3'h7, port_power_switch_n);
        mode_ctrl <= 16'h0005;
        port_power_on <= 3'h7;
        analog_overcurrent <= 1'b1;
        tick(6);
        check("oc_analog", 3'h7, port_power_switch_n);
        analog_overcurrent <= 1'b0;
        port_power_on <= 3'h0;
        tick(4);
        $display("test overcurrent done");
        // suspend and the three wake sources
        irq_enable <= 8'h03;
        suspend_req <= 1'b1;
        wait_clk(1'b0, 400);
        suspend_req <= 1'b0;
        tick(2);
        check("sleep_clk", 1'b0, main_clk_en);
        check("sleep_pin", 1'b1, pin_level);
        gpio_low <= 1'b1;
        wait_clk(1'b1, 400);
        gpio_low <= 1'b0;
        for (n = 0; n < UIW_READY_CYC && irq_status[UIW_EVT_READY] !== 1'b1; n++)
            tick(1);
        check("ready_evt", 1'b1, irq_status[UIW_EVT_READY]);
        check("awake_pin", 1'b0, pin_level);
        host_command_run <= 1'b1;
        tick(600);
        check("resume_kept", 1'b1, main_clk_en);
        host_command_run <= 1'b0;
        clear_status(8'hFF);
        suspend_req <= 1'b1;
        wait_clk(1'b0, 400);
        suspend_req <= 1'b0;
        chip_select_n <= 1'b0;
        wait_clk(1'b1, 400);
        chip_select_n <= 1'b1;
        check("cs_wake", 1'b1, main_clk_en);
        wait_clk(1'b0, 700);
        check("expiry", 1'b0, main_clk_en);
        port_change <= 1'b1;
        wait_clk(1'b1, 400);
        port_change <= 1'b0;
        host_command_run <= 1'b1;
        check("attach_wake", 1'b1, main_clk_en);
        $display("test suspend done");
        summarize();
    end
endmodule : usb_host_irq_and_wake_control_test
